/* File: verilog/acdc_pkg.sv */
// Package with register map, field layout and carrier types of the sample-clock control block.
// Contract
// RL1: Divider field codes 000, 001, 011, 111 divide input clock by 1, 2, 4, 8.
// RL2: Each channel keeps its own divider phase offset in half-cycle steps.
// RL3: Top bit of align control enables automatic divider phase adjust.
// RL4: Two-bit positive and negative skew windows allow zero to three device clocks.
// RL5: Software uses auto-phase and skew windows only with divide ratio above one.
// RL6: Setting fine delay enable bit 0 causes a datapath soft reset.
// RL7: Fine delay is two's complement; values at or below -88 saturate.
// RL8: Fine delay value takes effect only with the fine delay enable bit.
// RL9: Pin function field: 00 power-down, 01 standby, else pin disabled.
// RL10: The power-down/standby pin acts only while pin control enable is clear.
// RL11: Local registers apply to channels chosen by the channel page register.
package acdc_pkg;
  localparam logic [11:0] ADDR_PAGE      = 12'h008;
  localparam logic [11:0] ADDR_PIN_CTRL  = 12'h03F;
  localparam logic [11:0] ADDR_PIN_FUNC  = 12'h040;
  localparam logic [11:0] ADDR_DIV_RATIO = 12'h10B;
  localparam logic [11:0] ADDR_DIV_PHASE = 12'h10C;
  localparam logic [11:0] ADDR_ALIGN     = 12'h10D;
  localparam logic [11:0] ADDR_FD_EN     = 12'h117;
  localparam logic [11:0] ADDR_FD_VAL    = 12'h118;
  localparam logic [11:0] ADDR_STATUS    = 12'h11D;
  localparam logic [7:0] RST_PIN_FUNC = 8'h3F;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_PAGE     = 8'h03;
  localparam logic [2:0] DIV_BY1 = 3'h0;
  localparam logic [2:0] DIV_BY2 = 3'h1;
  localparam logic [2:0] DIV_BY4 = 3'h3;
  localparam logic [2:0] DIV_BY8 = 3'h7;
  localparam logic [2:0] PHASE_MAX = 3'h5;
  localparam logic signed [7:0] FD_MIN = 8'shA8;
  localparam logic [1:0] PIN_PDWN = 2'h0;
  localparam logic [1:0] PIN_STBY = 2'h1;
  localparam int AUTO_BIT = 7;
  localparam int PINEN_BIT = 7;
  localparam int FDEN_BIT = 0;
  localparam int SOFT_RST_CYC = 4;
  localparam int NCH = 2;

  typedef struct packed {
    logic [1:0] pin_mode;
    logic [2:0] fd_b_sel;
    logic [2:0] fd_a_sel;
  } acdc_pin_s;

  typedef struct packed {
    logic       auto_phase;
    logic [1:0] neg_skew;
    logic [1:0] pos_skew;
  } acdc_align_s;

  typedef struct packed {
    logic [3:0] div_ratio;
    logic [2:0] phase;
    logic       fine_en;
    logic signed [7:0] fine_delay;
  } acdc_chcfg_s;

  function automatic logic [3:0] acdc_ratio(input logic [2:0] code);
    case (code)
      DIV_BY2: acdc_ratio = 4'h2;
      DIV_BY4: acdc_ratio = 4'h4;
      DIV_BY8: acdc_ratio = 4'h8;
      default: acdc_ratio = 4'h1;
    endcase
  endfunction
endpackage

/* File: verilog/acdc_ctrl.sv */
// Sample-clock divider, phase, fine delay and pin-function control with a register port.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module acdc_ctrl (
  input  wire logic                         ref_clk,      // Device clock, 100 MHz.
  input  wire logic                         nrst,         // Asynchronous active-low reset.
  input  wire logic                         clk_en,       // Freezes all state except the reset synchroniser while low.
  input  wire logic [11:0]                  reg_addr,     // Register address.
  input  wire logic [7:0]                   reg_wdata,    // Register write data.
  input  wire logic                         reg_wr,       // Write strobe.
  input  wire logic                         reg_rd,       // Read strobe.
  output logic      [7:0]                   reg_rdata,    // Read data, one cycle after strobe.
  input  wire logic                         powerdown_standby_pin, // External pin, asynchronous.
  output acdc_pkg::acdc_chcfg_s [1:0]       ch_cfg,       // Per-channel clock settings.
  output acdc_pkg::acdc_align_s             align_cfg,    // Effective auto-phase settings.
  output logic      [1:0]                   soft_rst,     // Per-channel datapath soft reset.
  output logic                              power_down,   // Pin asks for power-down.
  output logic                              standby,      // Pin asks for standby.
  output logic      [2:0]                   threshold_flag_out_a, // Output A source select.
  output logic      [2:0]                   threshold_flag_out_b  // Output B source select.
);
  import acdc_pkg::*;

  logic rs1_r, rs2_r;
  logic pin1_r, pin2_r;
  logic [1:0] page_r, page_nxt;
  logic [1:0] pinen_r, pinen_nxt;
  acdc_pin_s pin_r, pin_nxt;
  logic [2:0] div_r, div_nxt;
  acdc_align_s align_r, align_nxt;
  logic [2:0] phase_r [NCH], phase_nxt [NCH];
  logic [1:0] fden_r, fden_nxt;
  logic [7:0] fdval_r [NCH], fdval_nxt [NCH];
  logic [2:0] srcnt_r [NCH], srcnt_nxt [NCH];
  logic [7:0] rdata_nxt;
  logic [0:0] rsel;

  // True for registers that are kept once per channel and follow the page.
  function automatic logic is_local(input logic [11:0] a);
    case (a)
      ADDR_PIN_CTRL, ADDR_DIV_PHASE, ADDR_FD_EN, ADDR_FD_VAL: is_local = 1'b1;
      default: is_local = 1'b0;
    endcase
  endfunction

  // Reset release and pin synchronisers.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end

  // Two flops on the external pin, so no logic sees a metastable level.
  always_ff @(posedge ref_clk or negedge rs2_r) begin
    if (!rs2_r) begin
      pin1_r <= 1'b0;
      pin2_r <= 1'b0;
    end else if (clk_en) begin
      pin1_r <= powerdown_standby_pin;
      pin2_r <= pin1_r;
    end
  end

  // Readback uses the lowest selected channel for local registers.
  assign rsel = page_r[0] ? 1'b0 : 1'b1;

  // Register writes, soft-reset counters and readback.
  always_comb begin
    page_nxt  = page_r;
    pinen_nxt = pinen_r;
    pin_nxt   = pin_r;
    div_nxt   = div_r;
    align_nxt = align_r;
    fden_nxt  = fden_r;
    phase_nxt = phase_r;
    fdval_nxt = fdval_r;
    rdata_nxt = RST_ZERO;
    for (int c = 0; c < NCH; c++) begin
      srcnt_nxt[c] = (srcnt_r[c] != 3'h0) ? srcnt_r[c] - 3'h1 : 3'h0;
    end
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PAGE:      page_nxt = reg_wdata[1:0];
        ADDR_PIN_FUNC:  pin_nxt = reg_wdata;
        ADDR_DIV_RATIO: div_nxt = reg_wdata[2:0];
        ADDR_ALIGN:     align_nxt = {reg_wdata[AUTO_BIT], reg_wdata[3:0]}; // RL3 RL4
        default: begin
        end
      endcase
      for (int c = 0; c < NCH; c++) begin
        if (page_r[c] && is_local(reg_addr)) begin // RL11
          case (reg_addr)
            ADDR_PIN_CTRL:  pinen_nxt[c] = reg_wdata[PINEN_BIT];
            ADDR_DIV_PHASE: phase_nxt[c] = (reg_wdata[2:0] > PHASE_MAX) ? PHASE_MAX : reg_wdata[2:0]; // RL2
            ADDR_FD_VAL:    fdval_nxt[c] = reg_wdata;
            ADDR_FD_EN: begin
              fden_nxt[c] = reg_wdata[FDEN_BIT];
              if (reg_wdata[FDEN_BIT] && !fden_r[c]) begin
                srcnt_nxt[c] = 3'(SOFT_RST_CYC); // RL6
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_PAGE:      rdata_nxt = {6'h00, page_r};
        ADDR_PIN_CTRL:  rdata_nxt = {pinen_r[rsel], 7'h00};
        ADDR_PIN_FUNC:  rdata_nxt = pin_r;
        ADDR_DIV_RATIO: rdata_nxt = {5'h00, div_r};
        ADDR_DIV_PHASE: rdata_nxt = {5'h00, phase_r[rsel]};
        ADDR_ALIGN:     rdata_nxt = {align_r.auto_phase, 3'h0, align_r.neg_skew, align_r.pos_skew};
        ADDR_FD_EN:     rdata_nxt = {7'h00, fden_r[rsel]};
        ADDR_FD_VAL:    rdata_nxt = fdval_r[rsel];
        ADDR_STATUS:    rdata_nxt = {6'h00, srcnt_r[1] != 3'h0, srcnt_r[0] != 3'h0};
        default:        rdata_nxt = RST_ZERO;
      endcase
    end
  end

  // Register state; nothing moves while the clock enable is low.
  always_ff @(posedge ref_clk or negedge rs2_r) begin
    if (!rs2_r) begin
      page_r    <= RST_PAGE[1:0];
      pinen_r   <= 2'h0;
      pin_r     <= RST_PIN_FUNC;
      div_r     <= DIV_BY1;
      align_r   <= '0;
      fden_r    <= 2'h0;
      reg_rdata <= RST_ZERO;
      for (int c = 0; c < NCH; c++) begin
        phase_r[c] <= 3'h0;
        fdval_r[c] <= RST_ZERO;
        srcnt_r[c] <= 3'h0;
      end
    end else if (clk_en) begin
      page_r    <= page_nxt;
      pinen_r   <= pinen_nxt;
      pin_r     <= pin_nxt;
      div_r     <= div_nxt;
      align_r   <= align_nxt;
      fden_r    <= fden_nxt;
      reg_rdata <= rdata_nxt;
      phase_r   <= phase_nxt;
      fdval_r   <= fdval_nxt;
      srcnt_r   <= srcnt_nxt;
    end
  end

  // Effective outputs, all registered.
  acdc_chcfg_s [1:0] cfg_nxt;
  acdc_align_s       aln_nxt;
  logic [1:0]        srst_nxt;
  logic              pd_nxt, sb_nxt, pin_live;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      cfg_nxt[c].div_ratio  = acdc_ratio(div_r); // RL1
      cfg_nxt[c].phase      = phase_r[c];        // RL2
      cfg_nxt[c].fine_en    = fden_r[c];
      if (!fden_r[c]) begin
        cfg_nxt[c].fine_delay = 8'sh00;          // RL8
      end else if ($signed(fdval_r[c]) <= FD_MIN) begin
        cfg_nxt[c].fine_delay = FD_MIN;          // RL7
      end else begin
        cfg_nxt[c].fine_delay = $signed(fdval_r[c]);
      end
      srst_nxt[c] = (srcnt_r[c] != 3'h0);        // RL6
    end
    // Auto-phase is meaningful only with division above one.
    aln_nxt = (div_r != DIV_BY1) ? align_r : '0; // RL5 RL3 RL4
    pin_live = pin2_r && !pinen_r[0];            // RL10
    pd_nxt = pin_live && (pin_r.pin_mode == PIN_PDWN); // RL9
    sb_nxt = pin_live && (pin_r.pin_mode == PIN_STBY); // RL9
  end

  // Output flops, so every top-level output leaves straight from a register.
  always_ff @(posedge ref_clk or negedge rs2_r) begin
    if (!rs2_r) begin
      ch_cfg     <= '0;
      align_cfg  <= '0;
      soft_rst   <= 2'h0;
      power_down <= 1'b0;
      standby    <= 1'b0;
      threshold_flag_out_a <= RST_PIN_FUNC[2:0];
      threshold_flag_out_b <= RST_PIN_FUNC[5:3];
    end else if (clk_en) begin
      ch_cfg     <= cfg_nxt;
      align_cfg  <= aln_nxt;
      soft_rst   <= srst_nxt;
      power_down <= pd_nxt;
      standby    <= sb_nxt;
      threshold_flag_out_a <= pin_r.fd_a_sel;
      threshold_flag_out_b <= pin_r.fd_b_sel;
    end
  end

  // Checks on the clock, pin and paging behaviour.
  a_div_ratio_map: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL1
    clk_en && div_r == DIV_BY4 |=> ch_cfg[0].div_ratio == 4'h4) else $error("divide ratio wrong");
  a_phase_limit: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL2
    ch_cfg[1].phase <= PHASE_MAX) else $error("phase beyond range");
  a_auto_gate: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL3
    clk_en && div_r == DIV_BY1 |=> !align_cfg.auto_phase) else $error("auto phase at divide one");
  a_skew_follow: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL4
    clk_en && div_r != DIV_BY1 |=> align_cfg.pos_skew == $past(align_r.pos_skew)) else $error("skew lost");
  a_soft_reset: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL6
    clk_en && reg_wr && reg_addr == ADDR_FD_EN && reg_wdata[0] && page_r[0] && !fden_r[0]
    ##1 clk_en[*2] |-> soft_rst[0]) else $error("no soft reset");
  a_fine_sat: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL7
    ch_cfg[0].fine_delay >= FD_MIN) else $error("fine delay not saturated");
  a_fine_gate: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL8
    !ch_cfg[0].fine_en |-> ch_cfg[0].fine_delay == 8'sh00) else $error("fine delay without enable");
  a_pin_mode: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL9
    !(power_down && standby)) else $error("both pin modes");
  a_pin_enable: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL10
    clk_en && pinen_r[0] |=> !power_down && !standby) else $error("pin honoured while disabled");
  a_page_local: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL11
    clk_en && reg_wr && reg_addr == ADDR_DIV_PHASE && !page_r[1] |=> phase_r[1] == $past(phase_r[1]))
    else $error("unpaged channel changed");
  c_soft_reset: cover property (@(posedge ref_clk) soft_rst[1]);
  c_power_down: cover property (@(posedge ref_clk) power_down);
  c_auto_phase: cover property (@(posedge ref_clk) align_cfg.auto_phase);
  c_fine_sat:   cover property (@(posedge ref_clk) ch_cfg[0].fine_delay == FD_MIN && ch_cfg[0].fine_en);
  c_standby:    cover property (@(posedge ref_clk) standby);

  // Read data return to zero in any enabled cycle that follows no read.
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rs2_r)
    clk_en && !reg_rd |=> reg_rdata == RST_ZERO)
    else $error("read data not idle");
  // Divide-by-two code reaches channel B as well.
  a_div_by2: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL1
    clk_en && div_r == DIV_BY2 |=> ch_cfg[1].div_ratio == 4'h2)
    else $error("divide by two wrong");
  // Divide-by-eight code reaches channel B as well.
  a_div_by8: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL1
    clk_en && div_r == DIV_BY8 |=> ch_cfg[1].div_ratio == 4'h8)
    else $error("divide by eight wrong");
  // The auto-phase enable is passed on whenever division is active.
  a_auto_pass: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL3
    clk_en && div_r != DIV_BY1 |=> align_cfg.auto_phase == $past(align_r.auto_phase))
    else $error("auto phase lost");
  // The negative skew window is passed on whenever division is active.
  a_neg_skew: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL4
    clk_en && div_r != DIV_BY1 |=> align_cfg.neg_skew == $past(align_r.neg_skew))
    else $error("negative skew lost");
  // A live pin in power-down mode asks for power-down.
  a_pdwn_on: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL9
    clk_en && pin2_r && !pinen_r[0] && pin_r.pin_mode == PIN_PDWN |=> power_down)
    else $error("power down missing");
  // A live pin in standby mode asks for standby.
  a_standby_on: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL9
    clk_en && pin2_r && !pinen_r[0] && pin_r.pin_mode == PIN_STBY |=> standby)
    else $error("standby missing");
  // Any other pin mode leaves the pin without function.
  a_pin_off: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL9
    clk_en && pin_r.pin_mode != PIN_PDWN && pin_r.pin_mode != PIN_STBY |=> !power_down && !standby)
    else $error("disabled pin acted");
  // Writes to per-channel registers leave the shared divider alone.
  a_global_hold: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL11
    clk_en && reg_wr && is_local(reg_addr) |=> div_r == $past(div_r))
    else $error("shared register hit by local write");
  // A low clock enable freezes the channel settings.
  a_freeze_cfg: assert property (@(posedge ref_clk) disable iff (!rs2_r)
    !clk_en |=> $stable(ch_cfg))
    else $error("settings moved while frozen");
  // The output source selects follow the pin function register.
  a_flag_follow: assert property (@(posedge ref_clk) disable iff (!rs2_r)
    clk_en |=> threshold_flag_out_a == $past(pin_r.fd_a_sel) && threshold_flag_out_b == $past(pin_r.fd_b_sel))
    else $error("source select stale");

  // Per-channel checks, one copy for each channel.
  for (genvar g = 0; g < NCH; g++) begin : g_chk
    // The phase output follows the stored phase of its own channel.
    a_phase_follow: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL2
      clk_en |=> ch_cfg[g].phase == $past(phase_r[g]))
      else $error("phase output stale");
    // Soft reset stays low once the channel counter has run out.
    a_soft_len: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL6
      clk_en && srcnt_r[g] == 3'h0 |=> !soft_rst[g])
      else $error("soft reset too long");
    // Enabled values at or below the floor come out as the floor.
    a_fine_floor: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL7
      clk_en && fden_r[g] && $signed(fdval_r[g]) <= FD_MIN |=> ch_cfg[g].fine_delay == FD_MIN)
      else $error("fine delay not clamped");
    // Enabled values above the floor pass unchanged.
    a_fine_pass: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL8
      clk_en && fden_r[g] && $signed(fdval_r[g]) > FD_MIN |=> ch_cfg[g].fine_delay == $past(fdval_r[g]))
      else $error("fine delay not applied");
    // A phase write to an unpaged channel leaves that channel alone.
    a_phase_local: assert property (@(posedge ref_clk) disable iff (!rs2_r) // RL11
      clk_en && reg_wr && reg_addr == ADDR_DIV_PHASE && !page_r[g] |=> phase_r[g] == $past(phase_r[g]))
      else $error("unpaged phase changed");
  end
endmodule

/* File: bench/tb_top.sv */
// Self-checking testbench for the sample-clock control block.
`timescale 1ns/1ps
module tb_top;
  import acdc_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] d; int s; logic [15:0] e;} acdc_row_s;
  logic                 ref_clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 clk_en = 1'b1;
  logic [11:0]          reg_addr = 12'h000;
  logic [7:0]           reg_wdata = 8'h00;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [7:0]           reg_rdata;
  logic                 pin = 1'b0;
  acdc_chcfg_s [1:0]    ch_cfg;
  acdc_align_s          align_cfg;
  logic [1:0]           soft_rst;
  logic                 power_down;
  logic                 standby;
  logic [2:0]           fd_a;
  logic [2:0]           fd_b;
  int                   fails = 0;
  int                   comparisons = 0;
  int                   n;
  acdc_row_s            rows [11] = '{
    '{12'h10B, 8'h00, 0, 16'h0001}, '{12'h10B, 8'h01, 0, 16'h0002}, '{12'h10B, 8'h03, 0, 16'h0004},
    '{12'h10B, 8'h07, 0, 16'h0008}, '{12'h10C, 8'h00, 1, 16'h0000}, '{12'h10C, 8'h05, 1, 16'h0005},
    '{12'h10C, 8'h07, 1, 16'h0005}, '{12'h10D, 8'h80, 2, 16'h0010}, '{12'h10D, 8'h0D, 2, 16'h000D},
    '{12'h10D, 8'h8E, 2, 16'h001E}, '{12'h10B, 8'h00, 2, 16'h0000}};

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  acdc_ctrl uut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .powerdown_standby_pin(pin), .ch_cfg(ch_cfg),
    .align_cfg(align_cfg), .soft_rst(soft_rst), .power_down(power_down), .standby(standby),
    .threshold_flag_out_a(fd_a), .threshold_flag_out_b(fd_b));

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compares a value read over the register port.
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a derived configuration output.
  task automatic cmp_out(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t output %h expected %h", $time, got, exp);
    end
  endtask

  // One write cycle; returns at the edge that takes it.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // One read cycle; data are looked at in the following cycle.
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  // Lets derived outputs settle and moves to a quiet sampling point.
  task automatic settle(input int c);
    repeat (c) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  function automatic logic [15:0] pick(input int s);
    case (s)
      0: pick = {12'h000, ch_cfg[0].div_ratio};
      1: pick = {13'h0000, ch_cfg[0].phase};
      2: pick = {11'h000, align_cfg};
      default: pick = {8'h00, ch_cfg[0].fine_delay};
    endcase
  endfunction

  // Watchdog against a hung run.
  initial begin
    #200000;
    fails++;
    close_out();
  end

  // Main sequence.
  initial begin
    logic [7:0] d;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    settle(3);
    cmp_out({10'h000, fd_b, fd_a}, 16'h003F);
    rd(ADDR_PIN_FUNC, d); cmp_rd(d, 8'h3F);
    rd(ADDR_DIV_RATIO, d); cmp_rd(d, 8'h00);
    rd(ADDR_ALIGN, d); cmp_rd(d, 8'h00);
    rd(ADDR_FD_EN, d); cmp_rd(d, 8'h00);
    rd(ADDR_FD_VAL, d); cmp_rd(d, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      settle(2);
      cmp_out(pick(rows[i].s), rows[i].e);
    end
    $display("test table done");
    wr(ADDR_FD_VAL, 8'h10);
    settle(2);
    cmp_out(pick(3), 16'h0000);
    wr(ADDR_FD_EN, 8'h01);
    n = 0;
    for (int k = 0; k < 6 && soft_rst !== 2'b11; k++) @(negedge ref_clk);
    while (soft_rst === 2'b11 && n < 10) begin
      n++;
      @(negedge ref_clk);
    end
    cmp_out(n[15:0], SOFT_RST_CYC[15:0]);
    cmp_out(pick(3), 16'h0010);
    wr(ADDR_FD_VAL, 8'h80);
    settle(2);
    cmp_out(pick(3), 16'h00A8);
    wr(ADDR_FD_VAL, 8'hA9);
    settle(2);
    cmp_out(pick(3), 16'h00A9);
    $display("test fine delay done");
    @(posedge ref_clk);
    pin <= 1'b1;
    wr(ADDR_PIN_FUNC, 8'h1A);
    settle(4);
    cmp_out({11'h000, power_down, standby, fd_b == 3'h3, fd_a == 3'h2, 1'b0}, 16'h0016);
    wr(ADDR_PIN_FUNC, 8'h7F);
    settle(2);
    cmp_out({14'h0000, power_down, standby}, 16'h0001);
    wr(ADDR_PIN_FUNC, 8'hBF);
    settle(2);
    cmp_out({14'h0000, power_down, standby}, 16'h0000);
    wr(ADDR_PIN_FUNC, 8'h3F);
    wr(ADDR_PIN_CTRL, 8'h80);
    settle(2);
    cmp_out({14'h0000, power_down, standby}, 16'h0000);
    $display("test pin done");
    wr(ADDR_PAGE, 8'h01);
    wr(ADDR_DIV_PHASE, 8'h03);
    wr(ADDR_PAGE, 8'h02);
    wr(ADDR_DIV_PHASE, 8'h01);
    settle(2);
    cmp_out({5'h00, ch_cfg[1].phase, 5'h00, ch_cfg[0].phase}, 16'h0103);
    rd(ADDR_DIV_PHASE, d); cmp_rd(d, 8'h01);
    settle(1);
    cmp_rd(reg_rdata, 8'h00);
    wr(12'h050, 8'h5A);
    rd(12'h050, d); cmp_rd(d, 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(ADDR_DIV_RATIO, 8'h01);
    clk_en <= 1'b1;
    settle(2);
    cmp_out(pick(0), 16'h0001);
    $display("test paging done");
    @(posedge ref_clk);
    nrst <= 1'b0;
    settle(1);
    cmp_out({10'h000, fd_b, fd_a}, 16'h003F);
    cmp_out(pick(0), 16'h0000);
    @(posedge ref_clk);
    nrst <= 1'b1;
    settle(3);
    rd(ADDR_PAGE, d); cmp_rd(d, 8'h03);
    rd(ADDR_DIV_PHASE, d); cmp_rd(d, 8'h00);
    $display("test second reset done");
    close_out();
  end
endmodule
